// ### inc/crc16_pkg.sv
// Constants, states and carriers shared by the checksum engine and its testbench.
// Assumes one system clock and an 8-bit special-function register bus.
package crc16_pkg;

  localparam logic [15:0] CRC_POLY       = 16'h1021;
  localparam logic [15:0] CRC_RESET      = 16'h0000;

  localparam logic [7:0]  ADDR_BIT_REV   = 8'h96;
  localparam logic [7:0]  ADDR_AUX_CTRL  = 8'hA2;
  localparam logic [7:0]  ADDR_DATA_PORT = 8'hB6;
  localparam logic [7:0]  ADDR_FL_MODE   = 8'hE5;
  localparam logic [7:0]  ADDR_FL_ADDR_H = 8'hE6;
  localparam logic [7:0]  ADDR_FL_ADDR_L = 8'hE7;
  localparam logic [7:0]  ADDR_APP_BOUND = 8'hE8;
  localparam logic [7:0]  ADDR_SEQ_CMD   = 8'hE9;

  localparam int          SEL_LSB        = 4;
  localparam logic [1:0]  SEL_SEED_LOW   = 2'h0;
  localparam logic [1:0]  SEL_SEED_HIGH  = 2'h1;
  localparam logic [1:0]  SEL_INPUT      = 2'h3;

  localparam logic [7:0]  MODE_AUTO_CRC  = 8'h80;
  localparam logic [7:0]  KEY_FIRST      = 8'h46;
  localparam logic [7:0]  KEY_SECOND     = 8'hB9;
  localparam logic [8:0]  END_LOW_ONES   = 9'h1FF;

  localparam logic [7:0]  BYTE_RESET     = 8'h00;
  localparam logic [1:0]  SEL_RESET      = 2'h0;
  localparam logic [6:0]  BOUND_RESET    = 7'h00;

  localparam int          FIFO_WIDTH     = 8;
  localparam int          FIFO_DEPTH     = 8;

  typedef enum logic [1:0] {
    AUTO_IDLE  = 2'b00,
    AUTO_FETCH = 2'b01,
    AUTO_WAIT  = 2'b11,
    AUTO_DRAIN = 2'b10
  } auto_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } sfr_req_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } flash_req_s;

endpackage

// ### core/byte_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_q;
  logic [AW:0]      rdPtr_q;
  wire              push;
  wire              pop;
  wire              full;
  wire              empty;

  assign full     = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
  assign empty    = (wrPtr_q == rdPtr_q);
  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr_q[AW-1:0]];
  assign push     = inValid && !full;
  assign pop      = outReady && !empty;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_q + (AW+1)'(push);
      rdPtr_q <= rdPtr_q + (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ### core/crc16_engine.sv
// Checksum engine: shared data port, seed/result access, flash-fed stream,
// and the bit-order-reverse register, all on the special-function bus.
// Assumes the flash returns one byte per request with flashValid, in order.
//
// Notes on behaviour
// RULE1: Remainder is a 16-bit check with generator polynomial 0x1021.
// RULE2: Each written input byte is folded into the running remainder.
// RULE3: Port writes with selection 01/00 load seed high/low byte.
// RULE4: Port reads with selection 01/00 return result high/low byte.
// RULE5: Selection 11 write feeds data; 10 reserved both ways, 11 on read.
// RULE6: Selection lives in control bits 5:4; data port at own address.
// RULE7: Software loads both seed bytes, then writes data bytes.
// RULE8: A second path streams flash bytes into the checksum.
// RULE9: Software keeps selection at 11 throughout an auto run.
// RULE10: Software programs flash start address before triggering.
// RULE11: Region ends at boundary value over nine one bits.
// RULE12: Flash mode value 0x80 selects automatic flash read.
// RULE13: Key writes 0x46 then 0xB9 start the flash-fed run.
// RULE14: Software writes zeros into the reserved upper mode bits.
// RULE15: Bit-reverse register reads back the stored byte mirrored.
// RULE16: Non-reflected MSB-first update, finished in one clock.
// RULE17: Auto run stops after folding in the end-address byte.
`timescale 1ns/1ps
`default_nettype none
module crc16_engine (
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  input  wire crc16_pkg::sfr_req_s   sfrReq,
  output logic [7:0]                 sfrRdata,
  output crc16_pkg::flash_req_s      flashReq,
  input  wire logic [7:0]            flashData,
  input  wire logic                  flashValid,
  output logic                       autoBusy
);

  function automatic logic [15:0] crcByte(input logic [15:0] crc,
                                          input logic [7:0]  data);
    logic [15:0] c;
    c = crc ^ {data, 8'h00};
    for (int i = 0; i < 8; i++) begin
      c = c[15] ? ((c << 1) ^ crc16_pkg::CRC_POLY) : (c << 1); // RULE1
    end
    return c;
  endfunction

  function automatic logic [7:0] mirror(input logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[7-i] = b[i];
    end
    return r;
  endfunction

  // Register state
  logic [15:0]                 crc_q;
  logic [15:0]                 crc_d;
  logic [1:0]                  sel_q;
  logic [7:0]                  bitRev_q;
  logic [7:0]                  flMode_q;
  logic [7:0]                  flAddrHigh_q;
  logic [7:0]                  flAddrLow_q;
  logic [6:0]                  appBound_q;
  logic                        keyArmed_q;
  logic [7:0]                  rdata_q;
  logic [7:0]                  rdata_d;

  // Auto-reload state
  crc16_pkg::auto_state_e      state_q;
  crc16_pkg::auto_state_e      state_d;
  logic [15:0]                 curAddr_q;
  logic [15:0]                 curAddr_d;
  logic [15:0]                 endAddr_q;
  logic [15:0]                 endAddr_d;
  crc16_pkg::flash_req_s       flashReq_q;
  crc16_pkg::flash_req_s       flashReq_d;
  logic                        busy_q;

  // FIFO hookup
  wire                         fifoInValid;
  wire                         fifoInReady;
  wire                         fifoOutValid;
  wire                         fifoOutReady;
  wire  [7:0]                  fifoOutData;

  // Address decode
  wire                         wrPort;
  wire                         wrAux;
  wire                         wrBitRev;
  wire                         wrMode;
  wire                         wrAddrHigh;
  wire                         wrAddrLow;
  wire                         wrBound;
  wire                         wrSeq;
  wire                         seedLowWr;
  wire                         seedHighWr;
  wire                         dataWr;
  wire                         cpuOwnsCrc;
  wire                         startAuto;
  wire                         atEnd;
  wire  [7:0]                  portRead;
  wire  [7:0]                  readMux;

  assign wrPort     = sfrReq.wr && (sfrReq.addr == crc16_pkg::ADDR_DATA_PORT); // RULE6
  assign wrAux      = sfrReq.wr && (sfrReq.addr == crc16_pkg::ADDR_AUX_CTRL);
  assign wrBitRev   = sfrReq.wr && (sfrReq.addr == crc16_pkg::ADDR_BIT_REV);
  assign wrMode     = sfrReq.wr && (sfrReq.addr == crc16_pkg::ADDR_FL_MODE);
  assign wrAddrHigh = sfrReq.wr && (sfrReq.addr == crc16_pkg::ADDR_FL_ADDR_H);
  assign wrAddrLow  = sfrReq.wr && (sfrReq.addr == crc16_pkg::ADDR_FL_ADDR_L);
  assign wrBound    = sfrReq.wr && (sfrReq.addr == crc16_pkg::ADDR_APP_BOUND);
  assign wrSeq      = sfrReq.wr && (sfrReq.addr == crc16_pkg::ADDR_SEQ_CMD);

  // Selection 10 matches nothing, so reserved writes are dropped
  assign seedLowWr  = wrPort && (sel_q == crc16_pkg::SEL_SEED_LOW);  // RULE3
  assign seedHighWr = wrPort && (sel_q == crc16_pkg::SEL_SEED_HIGH); // RULE3
  assign dataWr     = wrPort && (sel_q == crc16_pkg::SEL_INPUT);     // RULE5

  // CPU access to the remainder wins; the flash stream simply waits a cycle
  assign cpuOwnsCrc   = seedLowWr || seedHighWr || dataWr;
  assign fifoOutReady = !cpuOwnsCrc;

  // Key sequence, only honoured in auto mode and while idle
  assign startAuto = wrSeq && keyArmed_q
                  && (sfrReq.wdata == crc16_pkg::KEY_SECOND)
                  && (flMode_q == crc16_pkg::MODE_AUTO_CRC)
                  && (state_q == crc16_pkg::AUTO_IDLE); // RULE13 RULE12

  assign atEnd = (curAddr_q == endAddr_q); // RULE17

  // Flash bytes enter only while a fetch is outstanding
  assign fifoInValid = flashValid && (state_q == crc16_pkg::AUTO_WAIT); // RULE8

  assign portRead = (sel_q == crc16_pkg::SEL_SEED_LOW)  ? crc_q[7:0]  :
                    (sel_q == crc16_pkg::SEL_SEED_HIGH) ? crc_q[15:8] :
                    8'h00; // RULE4 RULE5

  assign readMux =
    (sfrReq.addr == crc16_pkg::ADDR_DATA_PORT) ? portRead :
    (sfrReq.addr == crc16_pkg::ADDR_AUX_CTRL)  ? {2'h0, sel_q, 4'h0} :
    (sfrReq.addr == crc16_pkg::ADDR_BIT_REV)   ? mirror(bitRev_q) : // RULE15
    (sfrReq.addr == crc16_pkg::ADDR_FL_MODE)   ? flMode_q :
    (sfrReq.addr == crc16_pkg::ADDR_FL_ADDR_H) ? flAddrHigh_q :
    (sfrReq.addr == crc16_pkg::ADDR_FL_ADDR_L) ? flAddrLow_q :
    (sfrReq.addr == crc16_pkg::ADDR_APP_BOUND) ? {1'h0, appBound_q} :
    8'h00;

  always_comb begin
    rdata_d = sfrReq.rd ? readMux : 8'h00;
  end

  // Remainder update, one byte per clock, non-reflected
  always_comb begin
    crc_d = crc_q;
    if (seedLowWr) begin
      crc_d = {crc_q[15:8], sfrReq.wdata}; // RULE3
    end else if (seedHighWr) begin
      crc_d = {sfrReq.wdata, crc_q[7:0]}; // RULE3
    end else if (dataWr) begin
      crc_d = crcByte(crc_q, sfrReq.wdata); // RULE2 RULE16
    end else if (fifoOutValid) begin
      crc_d = crcByte(crc_q, fifoOutData); // RULE8 RULE16
    end
  end

  // Auto-reload sequencer
  always_comb begin
    state_d          = state_q;
    curAddr_d        = curAddr_q;
    endAddr_d        = endAddr_q;
    flashReq_d.valid = 1'b0;
    flashReq_d.addr  = flashReq_q.addr;
    case (state_q)
      crc16_pkg::AUTO_IDLE: begin
        if (startAuto) begin
          curAddr_d = {flAddrHigh_q, flAddrLow_q};
          endAddr_d = {appBound_q, crc16_pkg::END_LOW_ONES}; // RULE11
          state_d   = crc16_pkg::AUTO_FETCH;
        end
      end
      crc16_pkg::AUTO_FETCH: begin
        // A full buffer holds back the next fetch
        if (fifoInReady) begin
          flashReq_d.valid = 1'b1;
          flashReq_d.addr  = curAddr_q;
          state_d          = crc16_pkg::AUTO_WAIT;
        end
      end
      crc16_pkg::AUTO_WAIT: begin
        if (flashValid) begin
          if (atEnd) begin
            state_d = crc16_pkg::AUTO_DRAIN; // RULE17
          end else begin
            curAddr_d = curAddr_q + 16'h0001;
            state_d   = crc16_pkg::AUTO_FETCH;
          end
        end
      end
      crc16_pkg::AUTO_DRAIN: begin
        // Done once the last buffered byte has been folded in
        if (!fifoOutValid) begin
          state_d = crc16_pkg::AUTO_IDLE; // RULE17
        end
      end
      default: begin
        state_d = crc16_pkg::AUTO_IDLE;
      end
    endcase
  end

  byte_fifo #(
    .WIDTH (crc16_pkg::FIFO_WIDTH),
    .DEPTH (crc16_pkg::FIFO_DEPTH)
  ) flash_buffer (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (flashData),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData)
  );

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      crc_q <= crc16_pkg::CRC_RESET;
    end else begin
      crc_q <= crc_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sel_q    <= crc16_pkg::SEL_RESET;
      bitRev_q <= crc16_pkg::BYTE_RESET;
    end else begin
      if (wrAux) begin
        sel_q <= sfrReq.wdata[crc16_pkg::SEL_LSB +: 2]; // RULE6
      end
      if (wrBitRev) begin
        bitRev_q <= sfrReq.wdata; // RULE15
      end
    end
  end

  // Mode bits are stored whole; software keeps the upper ones clear
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flMode_q <= crc16_pkg::BYTE_RESET;
    end else if (wrMode) begin
      flMode_q <= sfrReq.wdata; // RULE12
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flAddrHigh_q <= crc16_pkg::BYTE_RESET;
      flAddrLow_q  <= crc16_pkg::BYTE_RESET;
      appBound_q   <= crc16_pkg::BOUND_RESET;
    end else begin
      if (wrAddrHigh) begin
        flAddrHigh_q <= sfrReq.wdata;
      end
      if (wrAddrLow) begin
        flAddrLow_q <= sfrReq.wdata;
      end
      if (wrBound) begin
        appBound_q <= sfrReq.wdata[6:0]; // RULE11
      end
    end
  end

  // Any command write other than the first key disarms the sequence
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      keyArmed_q <= 1'b0;
    end else if (wrSeq) begin
      keyArmed_q <= (sfrReq.wdata == crc16_pkg::KEY_FIRST); // RULE13
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q    <= crc16_pkg::AUTO_IDLE;
      curAddr_q  <= 16'h0000;
      endAddr_q  <= 16'h0000;
      flashReq_q <= '0;
      busy_q     <= 1'b0;
    end else begin
      state_q    <= state_d;
      curAddr_q  <= curAddr_d;
      endAddr_q  <= endAddr_d;
      flashReq_q <= flashReq_d;
      busy_q     <= (state_d != crc16_pkg::AUTO_IDLE);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata_q <= crc16_pkg::BYTE_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign sfrRdata = rdata_q;
  assign flashReq = flashReq_q;
  assign autoBusy = busy_q;

endmodule
`default_nettype wire

// ### testbench/crc16_engine_asserts.sv
// Port checker for the checksum engine.
// Assumes one clock domain; bound to the engine from the testbench file.
`timescale 1ns/1ps
`default_nettype none
module crc16_engine_asserts (
  input wire logic                  clk_sys,
  input wire logic                  reset,
  input wire crc16_pkg::sfr_req_s   sfrReq,
  input wire logic [7:0]            sfrRdata,
  input wire crc16_pkg::flash_req_s flashReq,
  input wire logic [7:0]            flashData,
  input wire logic                  flashValid,
  input wire logic                  autoBusy
);
  logic [7:0]      mirror_q;
  logic [15:0]     start_q;
  logic [6:0]      bound_q;
  logic [15:0]     prevAddr_q;
  logic            havePrev_q;
  wire logic [7:0] wAddr   = sfrReq.wr ? sfrReq.addr : 8'h00;
  wire logic [7:0] revIn   = {<<{sfrReq.wdata}};
  wire logic [7:0] rAddr   = sfrReq.addr;
  wire logic       mapped  = (rAddr == 8'h96) || (rAddr == 8'hA2) || (rAddr == 8'hB6) ||
                             (rAddr >= 8'hE5 && rAddr <= 8'hE9);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Shadows of what software wrote and of the last fetch address, so reads and fetches can be judged
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mirror_q   <= 8'h00;
      start_q    <= 16'h0000;
      bound_q    <= 7'h00;
      prevAddr_q <= 16'h0000;
      havePrev_q <= 1'b0;
    end else begin
      if (wAddr == crc16_pkg::ADDR_BIT_REV) mirror_q <= revIn;
      if (wAddr == crc16_pkg::ADDR_FL_ADDR_H) start_q[15:8] <= sfrReq.wdata;
      if (wAddr == crc16_pkg::ADDR_FL_ADDR_L) start_q[7:0] <= sfrReq.wdata;
      if (wAddr == crc16_pkg::ADDR_APP_BOUND) bound_q <= sfrReq.wdata[6:0];
      if (flashReq.valid) prevAddr_q <= flashReq.addr;
      havePrev_q <= autoBusy && (havePrev_q || flashReq.valid);
    end
  end
  a_rdata_idle_zero: assert property (!$past(sfrReq.rd) |-> sfrRdata == 8'h00)
    else $error("read data not zero outside a read");
  a_bitrev_mirror: assert property (
    sfrReq.rd && rAddr == crc16_pkg::ADDR_BIT_REV |=> sfrRdata == $past(mirror_q))
    else $error("bit-reverse read not mirrored");
  a_unmapped_read: assert property (sfrReq.rd && !mapped |=> sfrRdata == 8'h00)
    else $error("unmapped read not zero");
  a_key_start: assert property (
    $rose(autoBusy) |-> $past(wAddr == crc16_pkg::ADDR_SEQ_CMD &&
    sfrReq.wdata == crc16_pkg::KEY_SECOND)) else $error("run started without key");
  a_first_fetch: assert property (
    $rose(autoBusy) |=> flashReq.valid && flashReq.addr == start_q)
    else $error("first fetch missing or wrong address");
  a_fetch_pulse: assert property (flashReq.valid |=> !flashReq.valid)
    else $error("fetch request longer than one cycle");
  a_fetch_busy: assert property (flashReq.valid |-> autoBusy)
    else $error("fetch outside a run");
  a_fetch_ascend: assert property (
    flashReq.valid && havePrev_q |-> flashReq.addr == prevAddr_q + 16'h0001)
    else $error("fetch address not ascending by one");
  a_end_stop: assert property (
    flashReq.valid && havePrev_q |-> prevAddr_q != {bound_q, crc16_pkg::END_LOW_ONES})
    else $error("fetch past the end address");
  c_run_start: cover property ($rose(autoBusy));
  c_run_end: cover property ($fell(autoBusy));
  c_bitrev_read: cover property (sfrReq.rd && rAddr == crc16_pkg::ADDR_BIT_REV);
endmodule
`default_nettype wire

// ### testbench/crc16_engine_test.sv
// Self-checking bench for the checksum engine.
// Assumes the engine alone; the bench plays both the CPU and the flash.
`timescale 1ns/1ps
`default_nettype none
module crc16_engine_test;
  logic                  clk_sys    = 1'b0;
  logic                  reset      = 1'b1;
  crc16_pkg::sfr_req_s   req        = '0;
  logic [7:0]            rdata;
  crc16_pkg::flash_req_s fReq;
  logic [7:0]            flashData  = 8'h00;
  logic                  flashValid = 1'b0;
  logic                  autoBusy;
  int                    err_count  = 0;
  int                    checks     = 0;
  int                    reqCount   = 0;
  int                    lat        = 1;

  always #12.5 clk_sys = ~clk_sys;

  crc16_engine crc16_engine_inst (.clk_sys(clk_sys), .reset(reset), .sfrReq(req),
    .sfrRdata(rdata), .flashReq(fReq), .flashData(flashData), .flashValid(flashValid),
    .autoBusy(autoBusy));

  task automatic report_and_stop();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Strobe drops a full cycle before the next request can raise it
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #2;
    req.addr  = a;
    req.wdata = d;
    req.wr    = 1'b1;
    @(posedge clk_sys);
    #2;
    req.wr    = 1'b0;
  endtask
  task automatic rd_check(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    #2;
    req.addr = a;
    req.rd   = 1'b1;
    @(posedge clk_sys);
    #2;
    req.rd   = 1'b0;
    check({8'h00, rdata}, {8'h00, e});
  endtask
  task automatic sel(input logic [1:0] s);
    sfr_wr(crc16_pkg::ADDR_AUX_CTRL, {2'h0, s, 4'h0});
  endtask
  function automatic logic [15:0] crc_step(input logic [15:0] r, input logic [7:0] b);
    logic [15:0] c;
    c = r ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      c = c[15] ? ((c << 1) ^ crc16_pkg::CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
  function automatic logic [7:0] fbyte(input logic [15:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction
  // Flash side: latency alternates 1 and 4 cycles; data line inverts once released
  always begin
    @(posedge clk_sys);
    #1;
    if (fReq.valid === 1'b1) begin
      reqCount++;
      repeat (lat) @(posedge clk_sys);
      #2;
      flashData  = fbyte(fReq.addr);
      flashValid = 1'b1;
      @(posedge clk_sys);
      #2;
      flashValid = 1'b0;
      flashData  = ~flashData;
      lat = 5 - lat;
    end
  end
  task automatic seed_ffff();
    sel(2'h1);
    sfr_wr(crc16_pkg::ADDR_DATA_PORT, 8'hFF);
    sel(2'h0);
    sfr_wr(crc16_pkg::ADDR_DATA_PORT, 8'hFF);
  endtask
  task automatic auto_run(input logic [15:0] start, input logic [6:0] bnd);
    logic [15:0] model;
    logic [15:0] last;
    model    = 16'hFFFF;
    last     = {bnd, crc16_pkg::END_LOW_ONES};
    reqCount = 0;
    seed_ffff();
    sel(2'h3);
    sfr_wr(crc16_pkg::ADDR_FL_ADDR_H, start[15:8]);
    sfr_wr(crc16_pkg::ADDR_FL_ADDR_L, start[7:0]);
    sfr_wr(crc16_pkg::ADDR_APP_BOUND, {1'b0, bnd});
    sfr_wr(crc16_pkg::ADDR_SEQ_CMD, crc16_pkg::KEY_FIRST);
    sfr_wr(crc16_pkg::ADDR_SEQ_CMD, crc16_pkg::KEY_SECOND);
    @(posedge clk_sys);
    #2;
    check({15'h0000, autoBusy}, 16'h0001);
    for (int n = 0; n < 3000 && autoBusy !== 1'b0; n++) @(posedge clk_sys);
    #2;
    // A run that never ends is a mismatch here, not a silent pass
    check({15'h0000, autoBusy}, 16'h0000);
    for (logic [16:0] a = {1'b0, start}; a <= {1'b0, last}; a++) begin
      model = crc_step(model, fbyte(a[15:0]));
    end
    check(16'(reqCount), last - start + 16'h0001);
    sel(2'h0);
    rd_check(crc16_pkg::ADDR_DATA_PORT, model[7:0]);
    sel(2'h1);
    rd_check(crc16_pkg::ADDR_DATA_PORT, model[15:8]);
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    #2;
    reset = 1'b0;
    rd_check(crc16_pkg::ADDR_BIT_REV, 8'h00);
    rd_check(crc16_pkg::ADDR_DATA_PORT, 8'h00);
    rd_check(8'h10, 8'h00);
    sfr_wr(crc16_pkg::ADDR_BIT_REV, 8'hA0);
    rd_check(crc16_pkg::ADDR_BIT_REV, 8'h05);
    sfr_wr(crc16_pkg::ADDR_BIT_REV, 8'h01);
    rd_check(crc16_pkg::ADDR_BIT_REV, 8'h80);
    sfr_wr(crc16_pkg::ADDR_AUX_CTRL, 8'hFF);
    rd_check(crc16_pkg::ADDR_AUX_CTRL, 8'h30);
    sel(2'h1);
    sfr_wr(crc16_pkg::ADDR_DATA_PORT, 8'h12);
    sel(2'h0);
    sfr_wr(crc16_pkg::ADDR_DATA_PORT, 8'h34);
    rd_check(crc16_pkg::ADDR_DATA_PORT, 8'h34);
    sel(2'h1);
    rd_check(crc16_pkg::ADDR_DATA_PORT, 8'h12);
    seed_ffff();
    sel(2'h3);
    for (int i = 1; i < 10; i++) sfr_wr(crc16_pkg::ADDR_DATA_PORT, 8'h30 + 8'(i));
    rd_check(crc16_pkg::ADDR_DATA_PORT, 8'h00);
    sel(2'h2);
    sfr_wr(crc16_pkg::ADDR_DATA_PORT, 8'h55);
    rd_check(crc16_pkg::ADDR_DATA_PORT, 8'h00);
    sel(2'h0);
    rd_check(crc16_pkg::ADDR_DATA_PORT, 8'hB1);
    sel(2'h1);
    rd_check(crc16_pkg::ADDR_DATA_PORT, 8'h29);
    // Key with wrong mode, then a broken key sequence: neither may start
    sfr_wr(crc16_pkg::ADDR_SEQ_CMD, crc16_pkg::KEY_FIRST);
    sfr_wr(crc16_pkg::ADDR_SEQ_CMD, crc16_pkg::KEY_SECOND);
    sfr_wr(crc16_pkg::ADDR_FL_MODE, crc16_pkg::MODE_AUTO_CRC);
    rd_check(crc16_pkg::ADDR_FL_MODE, 8'h80);
    sfr_wr(crc16_pkg::ADDR_SEQ_CMD, crc16_pkg::KEY_FIRST);
    sfr_wr(crc16_pkg::ADDR_SEQ_CMD, 8'h00);
    sfr_wr(crc16_pkg::ADDR_SEQ_CMD, crc16_pkg::KEY_SECOND);
    repeat (4) @(posedge clk_sys);
    check({15'h0000, autoBusy}, 16'h0000);
    check(16'(reqCount), 16'h0000);
    auto_run(16'h01F6, 7'h00);
    auto_run(16'h03FD, 7'h01);
    report_and_stop();
  end
  initial begin
    #1000000;
    err_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule
bind crc16_engine crc16_engine_asserts crc16_engine_asserts_inst (.clk_sys(clk_sys),
  .reset(reset), .sfrReq(sfrReq), .sfrRdata(sfrRdata), .flashReq(flashReq),
  .flashData(flashData), .flashValid(flashValid), .autoBusy(autoBusy));
`default_nettype wire
